// ===== sem_host_defs.svh
`ifndef SEM_HOST_DEFS_SVH
`define SEM_HOST_DEFS_SVH

// ********************************************************************
// flag space geometry
// ********************************************************************
`define SEM_FLAG_COUNT   8
`define SEM_IDX_W        3
`define SEM_IDX_LAST     3'h7
`define SEM_DATA_W       9

// ********************************************************************
// timing
// ********************************************************************
`define SEM_CLK_MHZ      25
`define SEM_STROBE_NS    80
`define SEM_RECOVER_NS   40
`define SEM_STROBE_CYC   (((`SEM_STROBE_NS * `SEM_CLK_MHZ) + 999) / 1000)
`define SEM_RECOVER_CYC  (((`SEM_RECOVER_NS * `SEM_CLK_MHZ) + 999) / 1000)
`define SEM_MAX_POLLS    16

`endif

// ===== sem_host_pkg.sv
package sem_host_pkg;

  typedef enum logic [1:0] {
    OP_CLAIM,
    OP_RELEASE,
    OP_INIT
  } cmd_op_t;

  typedef enum {
    CY_IDLE,
    CY_SETUP,
    CY_STROBE,
    CY_RECOVER
  } cyc_state_t;

  typedef enum {
    M_INIT,
    M_IDLE,
    M_CLAIM_WR,
    M_CLAIM_RD,
    M_WITHDRAW,
    M_RELEASE
  } main_state_t;

endpackage

// ===== sem_cycle_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_defs.svh"

interface sem_cycle_if;
  logic                  start;
  logic                  wr;
  logic [`SEM_IDX_W-1:0] idx;
  logic                  wbit;
  logic                  done;
  logic                  rbit;

  modport ctrl (output start, output wr, output idx, output wbit, input done, input rbit);
  modport eng  (input start, input wr, input idx, input wbit, output done, output rbit);
endinterface

`default_nettype wire

// ===== sem_pin_cycle.sv
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_defs.svh"

module sem_pin_cycle
  import sem_host_pkg::*;
#(
  parameter int DATA_W      = `SEM_DATA_W,
  parameter int STROBE_CYC  = `SEM_STROBE_CYC,
  parameter int RECOVER_CYC = `SEM_RECOVER_CYC
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  sem_cycle_if.eng                   cy,
  output var  logic                  flag_space_select_n,
  output var  logic [`SEM_IDX_W-1:0] flag_index_lines,
  output var  logic                  rw_n,
  output var  logic                  oe_n,
  input  wire logic [DATA_W-1:0]     data_in,
  output var  logic [DATA_W-1:0]     data_out,
  output var  logic                  data_oe
);

  if (STROBE_CYC < 1 || STROBE_CYC > 16 || RECOVER_CYC < 1 || RECOVER_CYC > 16 || DATA_W < 1)
  begin : g_bad_param
    $error("sem_pin_cycle: unsupported timing or width");
  end

  cyc_state_t state_q;
  logic [3:0] cnt_q;
  logic       wr_q;
  logic       done_q;
  logic       rbit_q;

  assign cy.done = done_q;
  assign cy.rbit = rbit_q;

  // ******************************************************************
  // one pin cycle
  // ******************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q             <= CY_IDLE;
      cnt_q               <= 4'h0;
      wr_q                <= 1'h0;
      done_q              <= 1'h0;
      rbit_q              <= 1'h1;
      flag_space_select_n <= 1'h1;
      flag_index_lines    <= 3'h0;
      rw_n                <= 1'h1;
      oe_n                <= 1'h1;
      data_out            <= '0;
      data_oe             <= 1'h0;
    end
    else
    begin
      done_q <= 1'h0;
      unique case (state_q)
        CY_IDLE:
          if (cy.start)
          begin
            flag_space_select_n <= 1'h0;
            flag_index_lines    <= cy.idx;
            wr_q                <= cy.wr;
            data_out            <= {DATA_W{cy.wbit}};
            data_oe             <= cy.wr;
            state_q             <= CY_SETUP;
          end
        CY_SETUP:
        begin
          rw_n    <= ~wr_q;
          oe_n    <= wr_q;
          cnt_q   <= 4'(STROBE_CYC - 1);
          state_q <= CY_STROBE;
        end
        CY_STROBE:
          if (cnt_q == 4'h0)
          begin
            if (!wr_q)
            begin
              rbit_q <= data_in[0];
            end
            flag_space_select_n <= 1'h1;
            oe_n                <= 1'h1;
            rw_n                <= 1'h1;
            cnt_q               <= 4'(RECOVER_CYC - 1);
            state_q             <= CY_RECOVER;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        CY_RECOVER:
          if (cnt_q == 4'h0)
          begin
            data_oe <= 1'h0;
            done_q  <= 1'h1;
            state_q <= CY_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
      endcase
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  property p_index_stable;
    @(posedge ref_clk) disable iff (sys_rst)
    (!flag_space_select_n && $past(!flag_space_select_n)) |-> $stable(flag_index_lines);
  endproperty
  a_index_stable: assert property (p_index_stable) else $error("index moved while selected");

  property p_strobes_idle;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_q == CY_RECOVER || state_q == CY_IDLE) |-> (oe_n && flag_space_select_n && rw_n);
  endproperty
  a_strobes_idle: assert property (p_strobes_idle) else $error("strobe held between cycles");

endmodule

`default_nettype wire

// ===== sem_host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_defs.svh"


module sem_host_ctrl
  import sem_host_pkg::*;
#(
  parameter int DATA_W    = `SEM_DATA_W,
  parameter int MAX_POLLS = `SEM_MAX_POLLS
)
(
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       cmd_valid,
  input  wire logic [1:0]                 cmd_op,
  input  wire logic [`SEM_IDX_W-1:0]      cmd_index,
  output var  logic                       cmd_ready,
  output var  logic                       rsp_valid,
  output var  logic                       rsp_granted,
  output var  logic [`SEM_FLAG_COUNT-1:0] owned_flags,
  output var  logic                       mem_ce_n,
  output var  logic                       flag_space_select_n,
  output var  logic [`SEM_IDX_W-1:0]      flag_index_lines,
  output var  logic                       rw_n,
  output var  logic                       oe_n,
  input  wire logic [DATA_W-1:0]          data_in,
  output var  logic [DATA_W-1:0]          data_out,
  output var  logic                       data_oe
);

  if (MAX_POLLS < 1 || MAX_POLLS > 255)
  begin : g_bad_param
    $error("sem_host_ctrl: MAX_POLLS out of range");
  end

  sem_cycle_if cy ();

  main_state_t           state_q;
  logic                  issued_q;
  logic                  start_q;
  logic                  wr_q;
  logic                  wbit_q;
  logic [`SEM_IDX_W-1:0] idx_q;
  logic [7:0]            polls_q;

  assign cy.start = start_q;
  assign cy.wr    = wr_q;
  assign cy.idx   = idx_q;
  assign cy.wbit  = wbit_q;

  // ******************************************************************
  // pin cycle engine
  // ******************************************************************
  sem_pin_cycle #(
    .DATA_W (DATA_W)
  ) u_cycle (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .cy                  (cy.eng),
    .flag_space_select_n (flag_space_select_n),
    .flag_index_lines    (flag_index_lines),
    .rw_n                (rw_n),
    .oe_n                (oe_n),
    .data_in             (data_in),
    .data_out            (data_out),
    .data_oe             (data_oe)
  );

  // ******************************************************************
  // memory array stays deselected
  // ******************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_ce_n <= 1'h1;
    end
    else
    begin
      mem_ce_n <= 1'h1;
    end
  end

  // ******************************************************************
  // command sequencer
  // ******************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q     <= M_INIT;
      issued_q    <= 1'h0;
      start_q     <= 1'h0;
      wr_q        <= 1'h1;
      wbit_q      <= 1'h1;
      idx_q       <= 3'h0;
      polls_q     <= 8'h00;
      cmd_ready   <= 1'h0;
      rsp_valid   <= 1'h0;
      rsp_granted <= 1'h0;
      owned_flags <= '0;
    end
    else
    begin
      start_q   <= 1'h0;
      rsp_valid <= 1'h0;
      unique case (state_q)
        M_IDLE:
          if (cmd_valid)
          begin
            cmd_ready <= 1'h0;
            idx_q     <= cmd_index;
            polls_q   <= 8'h00;
            unique case (cmd_op)
              2'h0:    state_q <= M_CLAIM_WR;
              2'h1:    state_q <= M_RELEASE;
              default:
              begin
                idx_q   <= 3'h0;
                state_q <= M_INIT;
              end
            endcase
          end
        M_INIT:
          if (!issued_q)
          begin
            start_q  <= 1'h1;
            issued_q <= 1'h1;
            wr_q     <= 1'h1;
            wbit_q   <= 1'h1;
          end
          else if (cy.done)
          begin
            issued_q <= 1'h0;
            if (idx_q == `SEM_IDX_LAST)
            begin
              owned_flags <= '0;
              cmd_ready   <= 1'h1;
              state_q     <= M_IDLE;
            end
            else
            begin
              idx_q <= idx_q + 3'h1;
            end
          end
        M_CLAIM_WR:
          if (!issued_q)
          begin
            start_q  <= 1'h1;
            issued_q <= 1'h1;
            wr_q     <= 1'h1;
            wbit_q   <= 1'h0;
          end
          else if (cy.done)
          begin
            issued_q <= 1'h0;
            state_q  <= M_CLAIM_RD;
          end
        M_CLAIM_RD:
          if (!issued_q)
          begin
            start_q  <= 1'h1;
            issued_q <= 1'h1;
            wr_q     <= 1'h0;
          end
          else if (cy.done)
          begin
            issued_q <= 1'h0;
            if (!cy.rbit)
            begin
              owned_flags[idx_q] <= 1'h1;
              rsp_valid          <= 1'h1;
              rsp_granted        <= 1'h1;
              cmd_ready          <= 1'h1;
              state_q            <= M_IDLE;
            end
            else if (polls_q == 8'(MAX_POLLS - 1))
            begin
              state_q <= M_WITHDRAW;
            end
            else
            begin
              polls_q <= polls_q + 8'h01;
            end
          end
        M_WITHDRAW, M_RELEASE:
          if (!issued_q)
          begin
            start_q  <= 1'h1;
            issued_q <= 1'h1;
            wr_q     <= 1'h1;
            wbit_q   <= 1'h1;
          end
          else if (cy.done)
          begin
            issued_q           <= 1'h0;
            owned_flags[idx_q] <= 1'h0;
            rsp_valid          <= 1'h1;
            rsp_granted        <= (state_q == M_RELEASE);
            cmd_ready          <= 1'h1;
            state_q            <= M_IDLE;
          end
      endcase
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  property p_claim_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    (start_q && state_q == M_CLAIM_WR) |-> (wr_q && !wbit_q);
  endproperty
  a_claim_zero: assert property (p_claim_zero) else $error("claim not a zero write");

  property p_claim_readback;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_q == M_CLAIM_WR && cy.done) |=> (state_q == M_CLAIM_RD) ##1 (start_q && !wr_q);
  endproperty
  a_claim_readback: assert property (p_claim_readback) else $error("no read after claim");

  property p_fail_follow;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_q == M_CLAIM_RD && cy.done && cy.rbit) |=> ##[0:2] (start_q && (state_q == M_CLAIM_RD || state_q == M_WITHDRAW));
  endproperty
  a_fail_follow: assert property (p_fail_follow) else $error("failed claim left pending");

  property p_withdraw_one;
    @(posedge ref_clk) disable iff (sys_rst)
    (start_q && (state_q == M_WITHDRAW || state_q == M_RELEASE)) |-> (wr_q && wbit_q);
  endproperty
  a_withdraw_one: assert property (p_withdraw_one) else $error("withdraw not a one write");

  property p_init_ones;
    @(posedge ref_clk) disable iff (sys_rst)
    (start_q && state_q == M_INIT) |-> (wr_q && wbit_q && !cmd_ready);
  endproperty
  a_init_ones: assert property (p_init_ones) else $error("init write not a one");

  property p_grant_on_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    (rsp_valid && rsp_granted && !$past(state_q == M_RELEASE)) |-> ($past(cy.rbit) == 1'h0);
  endproperty
  a_grant_on_zero: assert property (p_grant_on_zero) else $error("grant without zero read");

  property p_select_low;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(start_q) |=> ##1 (!flag_space_select_n && flag_index_lines == $past(idx_q, 2));
  endproperty
  a_select_low: assert property (p_select_low) else $error("select or index wrong");

  c_grant: cover property (@(posedge ref_clk) disable iff (sys_rst) rsp_valid && rsp_granted && owned_flags != '0);
  c_withdraw: cover property (@(posedge ref_clk) disable iff (sys_rst) state_q == M_WITHDRAW && cy.done);
  c_release: cover property (@(posedge ref_clk) disable iff (sys_rst) state_q == M_RELEASE && cy.done);
  c_retry: cover property (@(posedge ref_clk) disable iff (sys_rst) state_q == M_CLAIM_RD && cy.done && cy.rbit);

endmodule

`default_nettype wire

// ===== sem_flag_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_defs.svh"

module sem_flag_dev_model
(
  input  wire logic                   a_sel_n,
  input  wire logic [`SEM_IDX_W-1:0]  a_idx,
  input  wire logic                   a_rw_n,
  input  wire logic                   a_oe_n,
  input  wire logic [`SEM_DATA_W-1:0] a_wdata,
  input  wire logic                   a_wdata_oe,
  output var  logic [`SEM_DATA_W-1:0] a_bus,
  input  wire logic                   b_sel_n,
  input  wire logic [`SEM_IDX_W-1:0]  b_idx,
  input  wire logic                   b_rw_n,
  input  wire logic                   b_oe_n,
  input  wire logic [`SEM_DATA_W-1:0] b_wdata,
  output var  logic [`SEM_DATA_W-1:0] b_rdata
);
  // ****
  // flag state
  // ****
  // arbitrary power-up contents
  logic [7:0]             req_a_q = 8'hF0;
  logic [7:0]             req_b_q = 8'hCF;
  logic [7:0]             own_a_q = 8'h0F;
  logic [7:0]             own_b_q = 8'h30;
  logic [`SEM_DATA_W-1:0] a_lat, b_lat, a_last;
  wire logic              a_we = !a_sel_n && !a_rw_n;
  wire logic              b_we = !b_sel_n && !b_rw_n;
  wire logic              a_re = !a_sel_n && !a_oe_n && a_rw_n;
  wire logic              b_re = !b_sel_n && !b_oe_n && b_rw_n;

  // latches, ownership, hand-over; ties go to side a
  task automatic put(input bit sb, input logic [2:0] i, input logic v);
    if (sb)
      req_b_q[i] = v;
    else
      req_a_q[i] = v;
    if (req_a_q[i])
      own_a_q[i] = 1'b0;
    if (req_b_q[i])
      own_b_q[i] = 1'b0;
    if (!own_a_q[i] && !own_b_q[i])
    begin
      own_a_q[i] = !req_a_q[i];
      own_b_q[i] = req_a_q[i] && !req_b_q[i];
    end
  endtask

  // ****
  // pin side
  // ****
  // bit zero taken at end of write strobe
  always @(negedge a_we)
    if ($time > 0)
      put(1'b0, a_idx, a_wdata[0]);
  always @(negedge b_we)
    if ($time > 0)
      put(1'b1, b_idx, b_wdata[0]);
  // flag spread on all bits, held while selected
  always @(posedge a_re)
    a_lat = {`SEM_DATA_W{!own_a_q[a_idx]}};
  always @(posedge b_re)
    b_lat = {`SEM_DATA_W{!own_b_q[b_idx]}};
  always @*
    if (a_wdata_oe)
      a_last = a_wdata;
    else if (a_re)
      a_last = a_lat;
  // released bus shows inverse of last level
  assign a_bus = a_wdata_oe ? a_wdata : (a_re ? a_lat : ~a_last);
  assign b_rdata = b_re ? b_lat : ~b_lat;
endmodule

`default_nettype wire

// ===== dual_port_semaphore_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_defs.svh"

module dual_port_semaphore_flags_tb;
  typedef logic [`SEM_DATA_W-1:0] word_t;
  // ****
  // wiring
  // ****
  logic                       ref_clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_granted;
  logic [1:0]                 cmd_op;
  logic [`SEM_IDX_W-1:0]      cmd_index, idx, b_idx;
  logic [`SEM_FLAG_COUNT-1:0] owned_flags;
  logic                       mem_ce_n, sel_n, rw_n, oe_n, dout_oe, b_sel_n, b_rw_n, b_oe_n;
  word_t                      bus, dout, b_wd, b_rd;
  int                         err_count, n_compared;

  sem_host_ctrl #(.MAX_POLLS(4)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_index(cmd_index), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_granted(rsp_granted),
    .owned_flags(owned_flags), .mem_ce_n(mem_ce_n), .flag_space_select_n(sel_n),
    .flag_index_lines(idx), .rw_n(rw_n), .oe_n(oe_n), .data_in(bus), .data_out(dout), .data_oe(dout_oe));

  sem_flag_dev_model dev_u (
    .a_sel_n(sel_n), .a_idx(idx), .a_rw_n(rw_n), .a_oe_n(oe_n), .a_wdata(dout), .a_wdata_oe(dout_oe),
    .a_bus(bus), .b_sel_n(b_sel_n), .b_idx(b_idx), .b_rw_n(b_rw_n), .b_oe_n(b_oe_n), .b_wdata(b_wd),
    .b_rdata(b_rd));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****
  // helpers
  // ****
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [`SEM_FLAG_COUNT-1:0] got, input logic [`SEM_FLAG_COUNT-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic until_hi(input bit rsp);
    int n;
    n = 0;
    @(posedge ref_clk);
    while ((rsp ? rsp_valid : cmd_ready) !== 1'b1)
    begin
      n++;
      if (n > 500)
      begin
        err_count++;
        close_out();
      end
      @(posedge ref_clk);
    end
  endtask

  task automatic cmd(input logic [1:0] op, input logic [2:0] i);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_index <= i;
    until_hi(1'b0);
    cmd_valid <= 1'b0;
    if (op[1])
    begin
      tick(3);
      until_hi(1'b0);
    end
    else
      until_hi(1'b1);
  endtask

  task automatic b_wr(input logic [2:0] i, input logic v);
    @(posedge ref_clk);
    b_sel_n <= 1'b0;
    b_idx <= i;
    b_wd <= {~{8{v}}, v};
    @(posedge ref_clk);
    b_rw_n <= 1'b0;
    tick(2);
    b_rw_n <= 1'b1;
    b_sel_n <= 1'b1;
  endtask

  task automatic b_chk(input logic [2:0] i, input logic v);
    @(posedge ref_clk);
    b_sel_n <= 1'b0;
    b_idx <= i;
    b_oe_n <= 1'b0;
    tick(2);
    chk(b_rd, {`SEM_DATA_W{v}});
    b_sel_n <= 1'b1;
    b_oe_n <= 1'b1;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_start;
    until_hi(1'b0);
    for (int i = 0; i < 8; i++)
      b_wr(i[2:0], 1'b1);
    chk_flags(owned_flags, 8'h00);
  endtask

  task automatic t_pass;
    for (int i = 0; i < 8; i++)
    begin
      cmd(2'h0, i[2:0]);
      chk_bit(rsp_granted, 1'b1);
      chk_flags(owned_flags, 8'h01 << i);
      b_wr(i[2:0], 1'b0);
      b_chk(i[2:0], 1'b1);
      cmd(2'h1, i[2:0]);
      chk_flags(owned_flags, 8'h00);
      b_chk(i[2:0], 1'b0);
      b_wr(i[2:0], 1'b1);
    end
  endtask

  task automatic t_withdraw;
    b_wr(3'h2, 1'b0);
    b_chk(3'h2, 1'b0);
    cmd(2'h0, 3'h2);
    chk_bit(rsp_granted, 1'b0);
    chk_flags(owned_flags, 8'h00);
    b_wr(3'h2, 1'b1);
    b_wr(3'h2, 1'b0);
    b_chk(3'h2, 1'b0);
    b_wr(3'h2, 1'b1);
  endtask

  task automatic t_late;
    b_wr(3'h6, 1'b0);
    fork
      cmd(2'h0, 3'h6);
      begin
        tick(14);
        b_wr(3'h6, 1'b1);
      end
    join
    chk_bit(rsp_granted, 1'b1);
    chk_flags(owned_flags, 8'h40);
    b_wr(3'h6, 1'b0);
    b_chk(3'h6, 1'b1);
    cmd(2'h1, 3'h6);
    b_chk(3'h6, 1'b0);
    b_wr(3'h6, 1'b1);
  endtask

  task automatic t_reinit;
    for (int k = 2; k < 4; k++)
    begin
      cmd(2'h0, 3'h5);
      cmd(k[1:0], 3'h0);
      chk_flags(owned_flags, 8'h00);
      b_wr(3'h5, 1'b0);
      b_chk(3'h5, 1'b0);
      b_wr(3'h5, 1'b1);
    end
  endtask

  task automatic t_reset;
    cmd(2'h0, 3'h3);
    chk_flags(owned_flags, 8'h08);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    chk_flags(owned_flags, 8'h00);
    until_hi(1'b0);
    b_wr(3'h3, 1'b0);
    b_chk(3'h3, 1'b0);
    b_wr(3'h3, 1'b1);
  endtask

  initial
  begin
    err_count = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_index = 3'h0;
    b_sel_n = 1'b1;
    b_rw_n = 1'b1;
    b_oe_n = 1'b1;
    b_idx = 3'h0;
    b_wd = 9'h1FF;
    tick(6);
    sys_rst <= 1'b0;
    t_start();
    t_pass();
    t_withdraw();
    t_late();
    t_reinit();
    t_reset();
    chk_bit(mem_ce_n, 1'b1);
    close_out();
  end
endmodule

`default_nettype wire
